// ---- hdl/pso_pkg.sv ----
package pso_pkg;

    // ******************************************************
    // clock and timing
    // ******************************************************
    localparam int unsigned CLK_HZ           = 40_000_000;
    localparam int unsigned DBNC_SHORT_US    = 100;
    localparam int unsigned DBNC_LONG_MS     = 30;
    localparam int unsigned CHG_DBNC_MS      = 120;
    localparam int unsigned MRST_SHORT_S     = 8;
    localparam int unsigned MRST_LONG_S      = 16;
    localparam int unsigned TICK_US          = 100;
    // all long times count in 100 us ticks from one divider
    localparam int unsigned TICK_CYC         = (CLK_HZ / 1_000_000) * TICK_US;
    localparam int unsigned DBNC_SHORT_TICKS = DBNC_SHORT_US / TICK_US;
    localparam int unsigned DBNC_LONG_TICKS  = (DBNC_LONG_MS * 1000) / TICK_US;
    localparam int unsigned CHG_DBNC_TICKS   = (CHG_DBNC_MS * 1000) / TICK_US;
    localparam int unsigned MRST_SHORT_TICKS = (MRST_SHORT_S * 1_000_000) / TICK_US;
    localparam int unsigned MRST_LONG_TICKS  = (MRST_LONG_S * 1_000_000) / TICK_US;
    localparam int unsigned THERM_LIMIT_C    = 165;

    // ******************************************************
    // register map (avalon word addresses, byte offset = 4x)
    // ******************************************************
    localparam int unsigned ADDR_W       = 4;
    localparam logic [3:0]  REG_CTRL     = 4'h0;
    localparam logic [3:0]  REG_STATUS   = 4'h1;
    localparam logic [3:0]  REG_IRQ      = 4'h2;
    localparam logic [3:0]  REG_IRQ_MASK = 4'h3;
    localparam logic [3:0]  REG_ID       = 4'h4;

    // control fields
    localparam int unsigned CTRL_DBNC_SEL = 0;
    localparam int unsigned CTRL_STYLE    = 1;
    localparam int unsigned CTRL_MRST_SEL = 2;
    localparam int unsigned CTRL_PWR_OFF  = 3;
    localparam logic [3:0]  CTRL_RESET    = 4'h4;

    // interrupt bits
    localparam int unsigned IRQ_N      = 6;
    localparam int unsigned IRQ_FALL   = 0;
    localparam int unsigned IRQ_RISE   = 1;
    localparam int unsigned IRQ_UV     = 2;
    localparam int unsigned IRQ_OV     = 3;
    localparam int unsigned IRQ_THERM  = 4;
    localparam int unsigned IRQ_CHG    = 5;
    localparam logic [5:0]  MASK_RESET = 6'h3f;

    typedef enum logic [2:0] {
        PSO_ST_RESET   = 3'b000,
        PSO_ST_STANDBY = 3'b001,
        PSO_ST_CHECK   = 3'b010,
        PSO_ST_ON      = 3'b011,
        PSO_ST_DOWN    = 3'b100
    } pso_state_t;

endpackage

// ---- hdl/pso_debounce.sv ----
`timescale 1ns/1ps
module pso_debounce #(
    parameter int unsigned CNT_W = 12
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             tick,
    input  wire logic             raw,
    input  wire logic             rst_val,
    input  wire logic [CNT_W-1:0] limit,
    output logic                  level
);
    logic [CNT_W-1:0] cnt_r;

    initial begin
        if (CNT_W < 2) $error("pso_debounce: CNT_W too small");
    end

    // level follows raw only after raw differs for limit ticks in a row
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_r <= '0;
            level <= rst_val;
        end else if (srst == 1'b0 && raw == level) begin
            cnt_r <= '0;
        end else if (tick) begin
            if (cnt_r + 1'b1 >= limit) begin
                level <= raw;
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

endmodule // pso_debounce

// ---- hdl/pso_supervisor.sv ----
// Chosen here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
// Notes on behaviour
// - internal reset held at 1 while supply below por threshold, 0 after
// - undervoltage flag raised when supply below lockout threshold in check or on state
// - undervoltage comparator disabled and ignored in standby
// - leaving standby enables undervoltage check; pass goes on, fail returns standby
// - overvoltage report inhibits operation
// - overvoltage comparator disabled and ignored in standby
// - thermal flag above 165 C forces shutdown
// - charger wake only after valid held stable for 120 ms
// - on-key debounced, 100 us or 30 ms chosen by a control bit
// - separate maskable rise and fall flags for debounced on-key
// - style bit 0 push-button, 1 slide-switch
// - debounced falling on-key edge starts power-up in both styles
// - manual reset only acts in the on state
// - push-button: key low for period powers down to standby
// - slide-switch: key high for period powers down to standby
// - each interrupt source has its own mask bit
// - irq_out_n low while any unmasked flag is set
// - all mask bits set after reset
module pso_supervisor
    import pso_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC,
    parameter int unsigned MRST_SHORT  = MRST_SHORT_TICKS,
    parameter int unsigned MRST_LONG   = MRST_LONG_TICKS,
    parameter int unsigned CHG_DBNC    = CHG_DBNC_TICKS,
    parameter logic [7:0]  ID_VALUE    = 8'h5a
) (
    input  wire logic               clk,
    input  wire logic               srst,
    input  wire logic               por_below,
    input  wire logic               undervoltage_lockout_below,
    input  wire logic               overvoltage_lockout_above,
    input  wire logic               therm_over,
    input  wire logic               chg_valid,
    input  wire logic               onkey_n,
    input  wire logic [ADDR_W-1:0]  avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    output logic [31:0]             avs_readdata,
    output logic                    avs_waitrequest,
    output logic                    supply_reset_hold,
    output logic                    supply_under_flag,
    output logic                    undervoltage_lockout_enable,
    output logic                    overvoltage_lockout_enable,
    output logic                    regulators_on,
    output logic                    irq_out_n
);
    // ******************************************************
    // declarations
    // ******************************************************
    localparam int unsigned MRST_W = $clog2(MRST_LONG + 1) + 1;
    localparam int unsigned DB_W   = $clog2(CHG_DBNC + DBNC_LONG_TICKS + 1) + 1;

    pso_state_t       state_r;
    pso_state_t       state_nxt;
    logic [15:0]      div_r;
    logic             tick;
    logic             rst_hold;
    logic [3:0]       ctrl_r;
    logic [5:0]       irq_r;
    logic [5:0]       mask_r;
    logic             key_lvl;
    logic             key_lvl_d_r;
    logic             chg_lvl;
    logic             chg_lvl_d_r;
    logic             key_fall;
    logic             key_rise;
    logic             chg_wake;
    logic [DB_W-1:0]  key_limit;
    logic [MRST_W-1:0] mrst_cnt_r;
    logic [MRST_W-1:0] mrst_limit;
    logic             mrst_active;
    logic             mrst_fire;
    logic             uv_seen;
    logic             ov_seen;
    logic             fault;
    logic [5:0]       irq_set;
    logic             wr_irq;
    logic             rd_pend_r;

    initial begin
        if (TICK_CYCLES < 2 || TICK_CYCLES > 65535) $error("pso_supervisor: bad TICK_CYCLES");
        if (MRST_SHORT < 1 || MRST_SHORT > MRST_LONG) $error("pso_supervisor: bad MRST");
    end

    // ******************************************************
    // supply reset and tick divider
    // ******************************************************
    // por comparator overrides everything as a reset source
    assign rst_hold = srst | por_below;
    assign supply_reset_hold = rst_hold;

    always_ff @(posedge clk) begin
        if (rst_hold || tick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 16'h0001;
        end
    end
    assign tick = (div_r == 16'(TICK_CYCLES - 1));

    // ******************************************************
    // debouncers
    // ******************************************************
    // key is debounced in its active-high sense so reset level means released
    assign key_limit = ctrl_r[CTRL_DBNC_SEL] ? DB_W'(DBNC_LONG_TICKS)
                                             : DB_W'(DBNC_SHORT_TICKS);

    pso_debounce #(.CNT_W(DB_W)) u_key_dbnc (
        .clk     (clk),
        .srst    (rst_hold),
        .tick    (tick),
        .raw     (~onkey_n),
        .rst_val (1'b0),
        .limit   (key_limit),
        .level   (key_lvl)
    );

    pso_debounce #(.CNT_W(DB_W)) u_chg_dbnc (
        .clk     (clk),
        .srst    (rst_hold),
        .tick    (tick),
        .raw     (chg_valid),
        .rst_val (1'b0),
        .limit   (DB_W'(CHG_DBNC)),
        .level   (chg_lvl)
    );

    always_ff @(posedge clk) begin
        if (rst_hold) begin
            key_lvl_d_r <= 1'b0;
            chg_lvl_d_r <= 1'b0;
        end else begin
            key_lvl_d_r <= key_lvl;
            chg_lvl_d_r <= chg_lvl;
        end
    end
    // pin falling = key pressed = debounced level rising
    assign key_fall = key_lvl & ~key_lvl_d_r;
    assign key_rise = ~key_lvl & key_lvl_d_r;
    assign chg_wake = chg_lvl & ~chg_lvl_d_r;

    // ******************************************************
    // manual reset timer
    // ******************************************************
    assign mrst_limit = ctrl_r[CTRL_MRST_SEL] ? MRST_W'(MRST_LONG) : MRST_W'(MRST_SHORT);
    // timed state: pressed in push-button style, released in slide style
    assign mrst_active = (state_r == PSO_ST_ON) &&
                         (ctrl_r[CTRL_STYLE] ? ~key_lvl : key_lvl);

    always_ff @(posedge clk) begin
        if (rst_hold || !mrst_active) begin
            mrst_cnt_r <= '0;
        end else if (tick && mrst_cnt_r < mrst_limit) begin
            mrst_cnt_r <= mrst_cnt_r + 1'b1;
        end
    end
    assign mrst_fire = mrst_active && (mrst_cnt_r >= mrst_limit);

    // ******************************************************
    // on/off control
    // ******************************************************
    // comparators are powered only outside standby
    assign undervoltage_lockout_enable = (state_r == PSO_ST_CHECK) || (state_r == PSO_ST_ON);
    assign overvoltage_lockout_enable = undervoltage_lockout_enable;
    assign uv_seen     = undervoltage_lockout_enable & undervoltage_lockout_below;
    assign ov_seen     = overvoltage_lockout_enable & overvoltage_lockout_above;
    assign supply_under_flag = uv_seen;
    assign fault       = uv_seen | ov_seen | therm_over;
    assign regulators_on = (state_r == PSO_ST_ON);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PSO_ST_RESET: begin
                state_nxt = PSO_ST_STANDBY;
            end
            PSO_ST_STANDBY: begin
                if ((key_fall || chg_wake) && !therm_over) begin
                    state_nxt = PSO_ST_CHECK;
                end
            end
            PSO_ST_CHECK: begin
                state_nxt = fault ? PSO_ST_STANDBY : PSO_ST_ON;
            end
            PSO_ST_ON: begin
                if (fault || mrst_fire || ctrl_r[CTRL_PWR_OFF]) begin
                    state_nxt = PSO_ST_DOWN;
                end
            end
            PSO_ST_DOWN: begin
                state_nxt = PSO_ST_STANDBY;
            end
            default: begin
                state_nxt = PSO_ST_RESET;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst_hold) begin
            state_r <= PSO_ST_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ******************************************************
    // control register and interrupts
    // ******************************************************
    always_ff @(posedge clk) begin
        if (rst_hold) begin
            ctrl_r <= CTRL_RESET;
            mask_r <= MASK_RESET;
        end else if (avs_write && !avs_waitrequest) begin
            if (avs_address == REG_CTRL) begin
                ctrl_r <= avs_writedata[3:0];
            end
            if (avs_address == REG_IRQ_MASK) begin
                mask_r <= avs_writedata[IRQ_N-1:0];
            end
        end else if (state_r != PSO_ST_ON) begin
            ctrl_r[CTRL_PWR_OFF] <= 1'b0;
        end
    end

    assign irq_set = {chg_wake, therm_over, ov_seen, uv_seen, key_rise, key_fall};
    assign wr_irq  = avs_write && !avs_waitrequest && (avs_address == REG_IRQ);

    // write one to clear; a new event in the same cycle wins
    always_ff @(posedge clk) begin
        if (rst_hold) begin
            irq_r <= '0;
        end else if (wr_irq) begin
            irq_r <= (irq_r & ~avs_writedata[IRQ_N-1:0]) | irq_set;
        end else begin
            irq_r <= irq_r | irq_set;
        end
    end

    assign irq_out_n = ~|(irq_r & ~mask_r);

    // ******************************************************
    // avalon slave: writes in one cycle, reads wait one cycle
    // ******************************************************
    always_ff @(posedge clk) begin
        if (rst_hold) begin
            rd_pend_r    <= 1'b0;
            avs_readdata <= '0;
        end else begin
            rd_pend_r <= avs_read && !rd_pend_r;
            case (avs_address)
                REG_CTRL:     avs_readdata <= {28'h0, ctrl_r};
                REG_STATUS:   avs_readdata <= {24'h0, chg_lvl, therm_over, ov_seen, uv_seen,
                                               key_lvl, state_r};
                REG_IRQ:      avs_readdata <= {26'h0, irq_r};
                REG_IRQ_MASK: avs_readdata <= {26'h0, mask_r};
                REG_ID:       avs_readdata <= {24'h0, ID_VALUE};      // arbitrary value
                default:      avs_readdata <= 32'h0;
            endcase
        end
    end
    assign avs_waitrequest = avs_read && !rd_pend_r;

    // ******************************************************
    // assertions
    // ******************************************************
    a_reset_hold: assert property (@(posedge clk) por_below |-> supply_reset_hold)
        else $error("reset not held below por");
    a_uv_standby: assert property (@(posedge clk) disable iff (rst_hold)
        (state_r == PSO_ST_STANDBY) |-> !supply_under_flag)
        else $error("uv flag seen in standby");
    a_ov_standby: assert property (@(posedge clk) disable iff (rst_hold)
        (state_r == PSO_ST_STANDBY) |-> !overvoltage_lockout_enable)
        else $error("ov comparator on in standby");
    a_check_fail: assert property (@(posedge clk) disable iff (rst_hold)
        (state_r == PSO_ST_CHECK && fault) |=> state_r == PSO_ST_STANDBY)
        else $error("failed check did not return to standby");
    a_fault_off: assert property (@(posedge clk) disable iff (rst_hold)
        (state_r == PSO_ST_ON && (ov_seen || therm_over)) |=> state_r == PSO_ST_DOWN)
        else $error("fault did not power down");
    a_wake_key: assert property (@(posedge clk) disable iff (rst_hold)
        (state_r == PSO_ST_STANDBY && key_fall && !therm_over) |=> state_r == PSO_ST_CHECK)
        else $error("key press did not wake");
    a_mrst_on_only: assert property (@(posedge clk) disable iff (rst_hold)
        mrst_fire |-> state_r == PSO_ST_ON)
        else $error("manual reset outside on");
    a_mrst_down: assert property (@(posedge clk) disable iff (rst_hold)
        mrst_fire |=> state_r == PSO_ST_DOWN ##1 state_r == PSO_ST_STANDBY)
        else $error("manual reset did not reach standby");
    a_irq_pin: assert property (@(posedge clk) disable iff (rst_hold)
        $rose(irq_r[IRQ_FALL]) && !mask_r[IRQ_FALL] |-> !irq_out_n)
        else $error("unmasked flag did not assert irq");
    a_mask_reset: assert property (@(posedge clk)
        $fell(rst_hold) |-> mask_r == MASK_RESET && irq_out_n)
        else $error("masks not set after reset");
endmodule // pso_supervisor

// ---- bench/pso_onkey_model.sv ----
`timescale 1ns/1ps
module pso_onkey_model (
    input  wire logic clk,
    input  wire logic press,
    input  wire logic bouncy,
    output logic      onkey_n
);
    logic       last_r    = 1'b0;
    logic [2:0] chatter_r = 3'h0;
    logic       onkey_r   = 1'b1;

    // contacts chatter for a few cycles after each throw when bouncy is set
    always @(posedge clk) begin
        last_r <= press;
        if (press != last_r && bouncy) begin
            chatter_r <= 3'h5;
        end else if (chatter_r != 3'h0) begin
            chatter_r <= chatter_r - 3'h1;
        end
    end

    // open contacts leave the line to its pull-up, closed ones pull it low
    always @(posedge clk) begin
        onkey_r <= chatter_r[0] ? press : !press;
    end
    assign onkey_n = onkey_r;
endmodule // pso_onkey_model

// ---- bench/pso_supervisor_tb.sv ----
`timescale 1ns/1ps
module pso_supervisor_tb;
    import pso_pkg::*;

    // ******************************
    // bench state and instances
    // ******************************
    // whole run needs about 3000 cycles
    localparam int LIMIT = 20000;
    logic              clk;
    logic              srst, por_below, undervoltage_lockout_below, overvoltage_lockout_above, therm_over, chg_valid;
    logic              onkey_n, press, bouncy;
    logic [ADDR_W-1:0] avs_address;
    logic              avs_read, avs_write, avs_waitrequest;
    logic [31:0]       avs_writedata, avs_readdata;
    logic              supply_reset_hold, supply_under_flag, undervoltage_lockout_enable, overvoltage_lockout_enable;
    logic              regulators_on, irq_out_n;
    int                miscompares, checks, cycles;

    // short tick and periods keep the timed paths within a few thousand cycles
    pso_supervisor #(.TICK_CYCLES(4), .MRST_SHORT(8), .MRST_LONG(16), .CHG_DBNC(12)) i_dut (
        .clk(clk), .srst(srst), .por_below(por_below), .undervoltage_lockout_below(undervoltage_lockout_below),
        .overvoltage_lockout_above(overvoltage_lockout_above), .therm_over(therm_over), .chg_valid(chg_valid),
        .onkey_n(onkey_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .supply_reset_hold(supply_reset_hold),
        .supply_under_flag(supply_under_flag), .undervoltage_lockout_enable(undervoltage_lockout_enable),
        .overvoltage_lockout_enable(overvoltage_lockout_enable), .regulators_on(regulators_on), .irq_out_n(irq_out_n));
    pso_onkey_model i_key (.clk(clk), .press(press), .bouncy(bouncy), .onkey_n(onkey_n));

    // ******************************
    // shared tasks
    // ******************************
    task automatic end_of_test();
        if (miscompares == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask

    task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_read    <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask

    task automatic key(input logic p);
        @(posedge clk);
        press <= p;
    endtask

    task automatic wait_reg(input logic want, input int lim, output int n);
        n = 0;
        while (regulators_on !== want && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask

    // ******************************
    // scenarios
    // ******************************
    task automatic t_reset();
        logic [31:0] d;
        @(negedge clk);
        chk(32'(irq_out_n), 32'h1, "irq after reset");
        bus_rd(REG_IRQ_MASK, d);
        chk(d, 32'h3f, "mask reset value");
        bus_rd(REG_CTRL, d);
        chk(d, 32'h4, "ctrl reset value");
        bus_rd(4'hf, d);
        chk(d, 32'h0, "unmapped read");
        @(posedge clk);
        por_below <= 1'b1;
        @(negedge clk);
        chk(32'(supply_reset_hold), 32'h1, "hold while supply low");
        @(posedge clk);
        por_below <= 1'b0;
        repeat (3) @(negedge clk);
        chk(32'(supply_reset_hold), 32'h0, "hold after supply good");
        bus_rd(REG_STATUS, d);
        chk(32'(d[2:0]), 32'(PSO_ST_STANDBY), "standby after reset");
    endtask

    task automatic t_standby();
        @(posedge clk);
        undervoltage_lockout_below <= 1'b1;
        overvoltage_lockout_above <= 1'b1;
        repeat (20) @(negedge clk);
        chk(32'({supply_under_flag, undervoltage_lockout_enable}), 32'h0, "uv ignored in standby");
        chk(32'(overvoltage_lockout_enable), 32'h0, "ov off in standby");
        @(posedge clk);
        undervoltage_lockout_below <= 1'b0;
        overvoltage_lockout_above <= 1'b0;
    endtask

    task automatic t_wake_irq();
        logic [31:0] d;
        int          n;
        bus_wr(REG_IRQ_MASK, 32'h3e);
        key(1'b1);
        wait_reg(1'b1, 100, n);
        chk(32'(regulators_on), 32'h1, "press powers up");
        @(negedge clk);
        chk(32'(irq_out_n), 32'h0, "unmasked fall flag drives irq");
        key(1'b0);
        repeat (20) @(posedge clk);
        bus_rd(REG_IRQ, d);
        chk(32'(d[1:0]), 32'h3, "fall and rise flags");
        bus_wr(REG_IRQ, 32'h1);
        @(negedge clk);
        chk(32'(irq_out_n), 32'h1, "masked rise flag quiet");
        bus_rd(REG_IRQ, d);
        chk(32'(d[1:0]), 32'h2, "rise flag left");
        bus_wr(REG_IRQ_MASK, 32'h3f);
    endtask

    task automatic t_mrst_push();
        int n;
        bus_wr(REG_CTRL, 32'h0);
        key(1'b1);
        repeat (20) @(posedge clk);
        key(1'b0);
        repeat (20) @(posedge clk);
        key(1'b1);
        repeat (24) @(posedge clk);
        chk(32'(regulators_on), 32'h1, "timer restarted by release");
        wait_reg(1'b0, 100, n);
        chk(32'(n >= 8 && n <= 36), 32'h1, "push hold powers down");
        repeat (100) @(posedge clk);
        chk(32'(regulators_on), 32'h0, "held key in standby");
        key(1'b0);
        bus_wr(REG_CTRL, 32'h4);
    endtask

    task automatic t_check_fail();
        int on_seen, bad, en;
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            undervoltage_lockout_below <= (k == 0);
            overvoltage_lockout_above <= (k == 1);
            therm_over <= (k == 2);
            key(1'b1);
            on_seen = 0;
            bad = 0;
            en = 0;
            repeat (150) begin
                @(posedge clk);
                on_seen += int'(regulators_on === 1'b1);
                en += int'(undervoltage_lockout_enable === 1'b1 && overvoltage_lockout_enable === 1'b1);
                bad += int'(undervoltage_lockout_enable === 1'b1 && supply_under_flag !== 1'b1 && k == 0);
            end
            chk(32'(on_seen), 32'h0, "fault blocks power-up");
            chk(32'(k == 2 || en > 0), 32'h1, "check enables comparators");
            chk(32'(bad), 32'h0, "under flag while enabled");
            key(1'b0);
            @(posedge clk);
            {undervoltage_lockout_below, overvoltage_lockout_above, therm_over} <= 3'h0;
            repeat (20) @(posedge clk);
        end
    endtask

    task automatic t_slide();
        int n;
        bus_wr(REG_CTRL, 32'h6);
        key(1'b1);
        wait_reg(1'b1, 100, n);
        chk(32'(regulators_on), 32'h1, "slide closed powers up");
        repeat (150) @(posedge clk);
        chk(32'(regulators_on), 32'h1, "slide held low stays on");
        key(1'b0);
        wait_reg(1'b0, 150, n);
        chk(32'(n >= 64 && n <= 100), 32'h1, "slide open powers down");
        bus_wr(REG_CTRL, 32'h4);
    endtask

    task automatic t_charger();
        int n;
        @(posedge clk);
        chg_valid <= 1'b1;
        repeat (30) @(posedge clk);
        chg_valid <= 1'b0;
        repeat (80) @(posedge clk);
        chk(32'(regulators_on), 32'h0, "short charger pulse ignored");
        chg_valid <= 1'b1;
        wait_reg(1'b1, 200, n);
        chk(32'(n >= 48 && n <= 120), 32'h1, "charger wake after debounce");
        therm_over <= 1'b1;
        wait_reg(1'b0, 20, n);
        chk(32'(regulators_on), 32'h0, "thermal shutdown");
        {therm_over, chg_valid} <= 2'h0;
    endtask

    task automatic t_soft_off();
        logic [31:0] d;
        int          n;
        key(1'b1);
        wait_reg(1'b1, 100, n);
        chk(32'(regulators_on), 32'h1, "press powers up again");
        bus_rd(REG_STATUS, d);
        chk(32'(d[3:0]), 32'({1'b1, PSO_ST_ON}), "status pressed and on");
        bus_wr(REG_CTRL, 32'hc);
        wait_reg(1'b0, 20, n);
        chk(32'(regulators_on), 32'h0, "software power-off");
        bus_rd(REG_CTRL, d);
        chk(d, 32'h4, "power-off bit self-clears");
        key(1'b0);
        repeat (20) @(posedge clk);
    endtask

    task automatic t_dbnc_long();
        logic [31:0] d;
        int          n;
        bus_wr(REG_CTRL, 32'h5);
        bus_wr(REG_IRQ, 32'h3f);
        bouncy <= 1'b1;
        key(1'b1);
        repeat (400) @(posedge clk);
        key(1'b0);
        repeat (100) @(posedge clk);
        chk(32'(regulators_on), 32'h0, "short press under long debounce");
        bus_rd(REG_IRQ, d);
        chk(32'(d[1:0]), 32'h0, "no edge flags from filtered press");
        key(1'b1);
        wait_reg(1'b1, 1500, n);
        chk(32'(n >= 1200 && n <= 1400), 32'h1, "long debounce wake");
        key(1'b0);
    endtask

    // ******************************
    // clock, timeout and sequence
    // ******************************
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            end_of_test();
        end
    end

    initial begin
        {srst, por_below, undervoltage_lockout_below, overvoltage_lockout_above, therm_over, chg_valid} = 6'h20;
        {press, bouncy, avs_read, avs_write} = 4'h0;
        avs_address = '0;
        avs_writedata = 32'h0;
        miscompares = 0;
        checks = 0;
        cycles = 0;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_standby();
        t_wake_irq();
        t_mrst_push();
        t_check_fail();
        t_slide();
        t_charger();
        t_soft_off();
        t_dbnc_long();
        end_of_test();
    end
endmodule // pso_supervisor_tb
